/* core/spi_baud_gen.sv */
`timescale 1ns/1ps
// half bit-period tick: (prescale + 1) * 2**rate bus clocks per half period
module spi_baud_gen (
  input wire logic core_clk, // bus clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic run, // counts only while high, restarts otherwise
  input wire logic [2:0] prescale_field, // divisor minus one
  input wire logic [2:0] rate_select_field, // power of two exponent
  output logic half_tick // one-cycle pulse each half bit period
);

  spi_pkg::baud_state_s s_r;
  spi_pkg::baud_state_s s_nxt;
  logic [7:0] rate_last;

  ////////////////////////////////////////////////////////////////////////
  // prescaler stage feeds the power-of-two stage
  always_comb begin
    rate_last = 8'((8'h01 << rate_select_field) - 8'h01);
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run) begin
      // restart so the first half period after a start is full length
      s_nxt.pre_cnt = spi_pkg::PRE_CNT_RST;
      s_nxt.rate_cnt = spi_pkg::RATE_CNT_RST;
    end else if (s_r.pre_cnt == prescale_field) begin
      s_nxt.pre_cnt = spi_pkg::PRE_CNT_RST;
      if ({1'b0, s_r.rate_cnt} == rate_last) begin
        s_nxt.rate_cnt = spi_pkg::RATE_CNT_RST;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.rate_cnt = 7'(s_r.rate_cnt + 7'h01);
      end
    end else begin
      s_nxt.pre_cnt = 3'(s_r.pre_cnt + 3'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_r <= '{spi_pkg::PRE_CNT_RST, spi_pkg::RATE_CNT_RST, 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign half_tick = s_r.tick;

endmodule

/* core/spi_core.sv */
`timescale 1ns/1ps
module spi_core (
  input wire logic core_clk, // bus clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic clock_gate_wr, // write strobe for clock gate bit
  input wire logic clock_gate_wdata, // new clock gate value
  input spi_pkg::ctrl_s ctrl, // control bits
  input wire logic data_wr, // pulse: write transmit buffer
  input wire logic [7:0] data_wdata, // byte to transmit
  input wire logic data_rd, // pulse: read receive buffer
  input wire logic mode_fault_clr, // pulse: clear mode fault flag
  input spi_pkg::pin_set_s pin_in, // levels seen on the four pins
  output spi_pkg::pin_set_s pin_out, // levels driven to the four pins
  output spi_pkg::pin_set_s pin_oe_n, // pin drive enables, low drives
  output logic [7:0] data_rdata, // receive buffer contents
  output logic receive_full_flag, // receive buffer holds unread byte
  output logic transmit_empty_flag, // transmit buffer may be written
  output logic mode_fault_flag, // select went low in mode fault use
  output logic clock_gate_bit, // module clock gate state
  output logic busy // transfer in progress
);

  spi_pkg::core_state_s s_r;
  spi_pkg::core_state_s s_nxt;
  logic half_tick;
  logic baud_run;
  logic en;
  logic mst;
  logic slv_sel;
  logic din;
  logic edge_evt;
  logic leading;
  logic sample_edge;
  logic [7:0] sh_next;
  logic done;
  logic fault_in;

  // shift one bit in, direction set by lsb first
  function automatic logic [7:0] shift_byte(input logic [7:0] sh,
                                            input logic b,
                                            input logic lsbf);
    logic [7:0] r;
    r = lsbf ? {b, sh[7:1]} : {sh[6:0], b};
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bit-rate clock for master transfers
  spi_baud_gen u_baud (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(baud_run),
    .prescale_field(ctrl.prescale_field),
    .rate_select_field(ctrl.rate_select_field),
    .half_tick(half_tick)
  );

  // generator only counts while the master is actually shifting
  assign baud_run = s_r.gate && en && mst && s_r.state == spi_pkg::ST_RUN;

  ////////////////////////////////////////////////////////////////////////
  // mode decode and serial data input selection
  always_comb begin
    en = ctrl.system_enable_bit;
    mst = ctrl.master_mode;
    slv_sel = en && !mst && !pin_in.ss;
    // mode fault: select input pulled low while master watches it
    fault_in = en && mst && ctrl.mode_fault_enable &&
               !ctrl.select_output_enable && !pin_in.ss;
    if (mst) begin
      // bidir master reads the shared MOSI pin; own bit when driving
      if (ctrl.bidir_pin_select) begin
        din = ctrl.bidir_output_enable ? s_r.pin_out.mosi : pin_in.mosi;
      end else begin
        din = pin_in.miso;
      end
    end else begin
      if (ctrl.bidir_pin_select) begin
        din = ctrl.bidir_output_enable ? s_r.pin_out.miso : pin_in.miso;
      end else begin
        din = pin_in.mosi;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock edge detection: own generator for master, pin edges for slave
  always_comb begin
    if (mst) begin
      edge_evt = s_r.state == spi_pkg::ST_RUN && half_tick;
    end else begin
      // deselected slave sees no edges at all
      edge_evt = slv_sel && s_r.ss_prev == 1'b0 &&
                 s_r.state == spi_pkg::ST_RUN &&
                 pin_in.sck != s_r.sck_prev;
    end
    leading = !s_r.edge_cnt[0];
    sample_edge = leading ^ ctrl.cpha;
    done = edge_evt && s_r.edge_cnt == spi_pkg::LAST_EDGE;
    sh_next = shift_byte(s_r.shreg, din, ctrl.lsb_first);
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer engine, buffers and flags
  always_comb begin
    s_nxt = s_r;
    s_nxt.sck_prev = pin_in.sck;
    s_nxt.ss_prev = pin_in.ss;
    if (clock_gate_wr) begin
      s_nxt.gate = clock_gate_wdata;
    end
    if (!s_r.gate) begin
      // gated off: everything else holds, as if the clock stood still
      s_nxt.sck_prev = s_r.sck_prev;
      s_nxt.ss_prev = s_r.ss_prev;
    end else if (!en) begin
      s_nxt.state = spi_pkg::ST_IDLE;
      s_nxt.tx_buf = spi_pkg::BUF_RST;
      s_nxt.rx_buf = spi_pkg::BUF_RST;
      s_nxt.shreg = spi_pkg::BUF_RST;
      s_nxt.tx_empty = 1'b1;
      s_nxt.rx_full = 1'b0;
      s_nxt.edge_cnt = spi_pkg::FIRST_EDGE;
      s_nxt.sample_bit = 1'b0;
      s_nxt.sck_lvl = ctrl.cpol;
    end else begin
      // reading frees the receive buffer; a new byte below wins
      if (data_rd) begin
        s_nxt.rx_full = 1'b0;
      end
      if (mode_fault_clr) begin
        s_nxt.mode_fault = 1'b0;
      end
      if (fault_in) begin
        s_nxt.mode_fault = 1'b1;
      end
      // software write lands in the transmit buffer
      if (data_wr) begin
        s_nxt.tx_buf = data_wdata;
        s_nxt.tx_empty = 1'b0;
      end
      case (s_r.state)
        spi_pkg::ST_IDLE: begin
          s_nxt.edge_cnt = spi_pkg::FIRST_EDGE;
          s_nxt.sck_lvl = ctrl.cpol;
          if (mst) begin
            // a master starts once the transmit buffer holds a byte; a fault blocks the start
            if (!s_r.tx_empty && !fault_in && !s_r.mode_fault) begin
              s_nxt.shreg = s_r.tx_buf;
              s_nxt.tx_empty = data_wr ? 1'b0 : 1'b1;
              s_nxt.state = spi_pkg::ST_RUN;
            end
          end else if (slv_sel && s_r.ss_prev) begin
            // select just fell: first bit must be ready before any edge
            if (!s_r.tx_empty) begin
              s_nxt.shreg = s_r.tx_buf;
              s_nxt.tx_empty = data_wr ? 1'b0 : 1'b1;
            end
            s_nxt.state = spi_pkg::ST_RUN;
          end
        end
        spi_pkg::ST_RUN: begin
          // fault or deselect abandons the byte; the partial byte is lost
          // and both buffers keep what they held
          if ((mst && fault_in) || (!mst && !slv_sel)) begin
            s_nxt.state = spi_pkg::ST_IDLE;
            s_nxt.edge_cnt = spi_pkg::FIRST_EDGE;
            s_nxt.sck_lvl = ctrl.cpol;
          end else if (edge_evt) begin
            s_nxt.edge_cnt = 4'(s_r.edge_cnt + 4'h1);
            if (mst) begin
              s_nxt.sck_lvl = ~s_r.sck_lvl;
            end
            if (sample_edge) begin
              s_nxt.sample_bit = din;
              // phase 1 ends on a sample edge: shift the last bit at once
              if (done) begin
                s_nxt.shreg = sh_next;
              end
            end else if (!(ctrl.cpha && s_r.edge_cnt == spi_pkg::FIRST_EDGE))
            begin
              s_nxt.shreg = shift_byte(s_r.shreg, s_r.sample_bit,
                                       ctrl.lsb_first);
            end
            if (done) begin
              // both endings leave the full byte in the next shifter value
              s_nxt.rx_buf = ctrl.cpha ? sh_next :
                             shift_byte(s_r.shreg, s_r.sample_bit,
                                        ctrl.lsb_first);
              s_nxt.rx_full = 1'b1;
              s_nxt.edge_cnt = spi_pkg::FIRST_EDGE;
              if (mst) begin
                s_nxt.state = spi_pkg::ST_IDLE;
              end else if (!s_r.tx_empty) begin
                // slave stays selected: next byte goes straight in
                s_nxt.shreg = s_r.tx_buf;
                s_nxt.tx_empty = data_wr ? 1'b0 : 1'b1;
              end
            end
          end
        end
        default: begin
          // unused code: fall back to idle rather than lock up
          s_nxt.state = spi_pkg::ST_IDLE;
        end
      endcase
    end
    // pin routing follows the next state so pins line up with the clock
    s_nxt.pin_oe_n = '{spi_pkg::OE_N_RST, spi_pkg::OE_N_RST,
                       spi_pkg::OE_N_RST, spi_pkg::OE_N_RST};
    s_nxt.pin_out = '{1'b0, 1'b0, 1'b0, 1'b1};
    if (!s_r.gate) begin
      s_nxt.pin_oe_n = s_r.pin_oe_n;
      s_nxt.pin_out = s_r.pin_out;
    end else if (en) begin
      if (mst) begin
        s_nxt.pin_out.sck = s_nxt.sck_lvl;
        s_nxt.pin_oe_n.sck = 1'b0;
        s_nxt.pin_out.mosi = ctrl.lsb_first ? s_nxt.shreg[0] :
                             s_nxt.shreg[7];
        // bidir master drives MOSI only with the output enable set
        s_nxt.pin_oe_n.mosi = ctrl.bidir_pin_select ?
                              !ctrl.bidir_output_enable : 1'b0;
        // MISO is an input, or released in bidir use
        s_nxt.pin_oe_n.miso = 1'b1;
        if (ctrl.mode_fault_enable && ctrl.select_output_enable) begin
          // automatic select: low for the whole byte
          s_nxt.pin_out.ss = s_nxt.state != spi_pkg::ST_RUN;
          s_nxt.pin_oe_n.ss = 1'b0;
        end
      end else begin
        // MOSI stays an input or is unused; a slave never drives it
        s_nxt.pin_oe_n.mosi = 1'b1;
        s_nxt.pin_out.miso = ctrl.lsb_first ? s_nxt.shreg[0] :
                             s_nxt.shreg[7];
        if (!pin_in.ss) begin
          s_nxt.pin_oe_n.miso = ctrl.bidir_pin_select ?
                                !ctrl.bidir_output_enable : 1'b0;
        end else begin
          s_nxt.pin_oe_n.miso = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; reset sets the clock gate and empties the buffers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_r.gate <= spi_pkg::GATE_RST;
      s_r.state <= spi_pkg::ST_IDLE;
      s_r.tx_buf <= spi_pkg::BUF_RST;
      s_r.tx_empty <= spi_pkg::TX_EMPTY_RST;
      s_r.rx_buf <= spi_pkg::BUF_RST;
      s_r.rx_full <= spi_pkg::RX_FULL_RST;
      s_r.shreg <= spi_pkg::BUF_RST;
      s_r.edge_cnt <= spi_pkg::FIRST_EDGE;
      s_r.sample_bit <= 1'b0;
      s_r.sck_lvl <= 1'b0;
      s_r.sck_prev <= 1'b0;
      s_r.ss_prev <= 1'b1;
      s_r.mode_fault <= 1'b0;
      s_r.pin_out <= '{1'b0, 1'b0, 1'b0, 1'b1};
      s_r.pin_oe_n <= '{spi_pkg::OE_N_RST, spi_pkg::OE_N_RST,
                        spi_pkg::OE_N_RST, spi_pkg::OE_N_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign pin_out = s_r.pin_out;
  assign pin_oe_n = s_r.pin_oe_n;
  assign data_rdata = s_r.rx_buf;
  assign receive_full_flag = s_r.rx_full;
  assign transmit_empty_flag = s_r.tx_empty;
  assign mode_fault_flag = s_r.mode_fault;
  assign clock_gate_bit = s_r.gate;
  // run is the only state with bit 0 set, so busy is a plain flop bit
  assign busy = s_r.state[0];

endmodule

/* core/spi_pkg.sv */
package spi_pkg;

  // byte width of buffers and shifter
  localparam int BYTE_W = 8;
  // last of the sixteen clock edges of one byte, counted from zero
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [3:0] FIRST_EDGE = 4'h0;
  // values after reset
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic GATE_RST = 1'b1;
  localparam logic TX_EMPTY_RST = 1'b1;
  localparam logic RX_FULL_RST = 1'b0;
  localparam logic OE_N_RST = 1'b1;
  localparam logic [2:0] PRE_CNT_RST = 3'h0;
  localparam logic [6:0] RATE_CNT_RST = 7'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } xfer_state_e;

  // one bit for each of the four shared pins
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } pin_set_s;

  // control bits, held by software outside this block
  typedef struct packed {
    logic system_enable_bit;
    logic master_mode;
    logic cpol;
    logic cpha;
    logic lsb_first;
    logic select_output_enable;
    logic mode_fault_enable;
    logic bidir_pin_select;
    logic bidir_output_enable;
    logic [2:0] prescale_field;
    logic [2:0] rate_select_field;
  } ctrl_s;

  typedef struct packed {
    logic [2:0] pre_cnt;
    logic [6:0] rate_cnt;
    logic tick;
  } baud_state_s;

  typedef struct packed {
    logic gate;
    xfer_state_e state;
    logic [7:0] tx_buf;
    logic tx_empty;
    logic [7:0] rx_buf;
    logic rx_full;
    logic [7:0] shreg;
    logic [3:0] edge_cnt;
    logic sample_bit;
    logic sck_lvl;
    logic sck_prev;
    logic ss_prev;
    logic mode_fault;
    pin_set_s pin_out;
    pin_set_s pin_oe_n;
  } core_state_s;

endpackage

/* tb/spi_core_bench.sv */
`timescale 1ns/1ps
module spi_core_bench;
  logic core_clk, resetn, clock_gate_wr, clock_gate_wdata;
  logic data_wr, data_rd, mode_fault_clr, s_sck, s_mosi, s_ss, m_miso;
  logic receive_full_flag, transmit_empty_flag, mode_fault_flag;
  logic clock_gate_bit, busy;
  logic [7:0] data_wdata, data_rdata, m_tx, m_rx;
  spi_pkg::ctrl_s ctrl;
  spi_pkg::pin_set_s pin_in, pin_out, pin_oe_n;
  int fails, total_checks;
  spi_core u_spi_core (
    .core_clk, .resetn, .clock_gate_wr, .clock_gate_wdata, .ctrl,
    .data_wr, .data_wdata, .data_rd, .mode_fault_clr, .pin_in,
    .pin_out, .pin_oe_n, .data_rdata, .receive_full_flag,
    .transmit_empty_flag, .mode_fault_flag, .clock_gate_bit, .busy
  );
  spi_slave_model u_spi_slave_model (.sck(pin_in.sck),
    .mosi(pin_in.mosi), .sel_n(s_ss), .tx_byte(m_tx), .miso(m_miso),
    .rx_byte(m_rx));
  // each wire resolves to whoever has its driver enabled
  assign pin_in = {pin_oe_n.sck ? s_sck : pin_out.sck,
    pin_oe_n.mosi ? s_mosi : pin_out.mosi,
    pin_oe_n.miso ? m_miso : pin_out.miso,
    pin_oe_n.ss ? s_ss : pin_out.ss};
  //////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_sim;
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task cfg(input logic m, b, o, f, s, input logic [2:0] p, r);
    ctrl = {1'b1, m, 3'h0, s, f, b, o, p, r};
    cyc(2);
  endtask
  task wr(input logic [7:0] d);
    data_wdata = d;
    data_wr = 1'b1;
    cyc(1);
    data_wr = 1'b0;
  endtask
  task rd;
    data_rd = 1'b1;
    cyc(1);
    data_rd = 1'b0;
  endtask
  task gate(input logic v);
    clock_gate_wdata = v;
    clock_gate_wr = 1'b1;
    cyc(1);
    clock_gate_wr = 1'b0;
  endtask
  // a hang here ends the run as a failure
  task wait_rx;
    for (int i = 0; i < 20000 && receive_full_flag !== 1'b1; i++) cyc(1);
    if (receive_full_flag !== 1'b1) begin
      fails++;
      end_sim;
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  task t_master(input logic [2:0] p, r, input logic [15:0] h);
    int n;
    s_ss = 1'b1;
    m_tx = 8'h3C;
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, p, r);
    s_ss = 1'b0;
    chk({12'h0, pin_oe_n}, 16'h0003);
    wr(8'hA5);
    n = 0;
    for (int i = 0; i < 3000 && pin_out.sck !== 1'b1; i++) cyc(1);
    for (int i = 0; i < 3000 && pin_out.sck === 1'b1; i++) begin
      cyc(1);
      n++;
    end
    // a clock that never rose or never fell ends the run as a failure
    if (n == 0 || pin_out.sck === 1'b1) begin
      fails++;
      end_sim;
    end
    chk(n[15:0], h);
    wait_rx;
    chk(data_rdata, 8'h3C);
    chk(m_rx, 8'hA5);
    rd;
    chk(receive_full_flag, 1'b0);
  endtask
  task t_off;
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1, 3'h1);
    wr(8'h5A);
    cyc(20);
    ctrl.system_enable_bit = 1'b0;
    cyc(2);
    chk({busy, transmit_empty_flag, receive_full_flag, pin_oe_n},
      16'h002F);
    wr(8'h11);
    chk(transmit_empty_flag, 1'b1);
  endtask
  task t_gate;
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
    gate(1'b0);
    wr(8'h22);
    cyc(2);
    chk({clock_gate_bit, transmit_empty_flag, busy}, 16'h2);
    gate(1'b1);
    chk(clock_gate_bit, 1'b1);
  endtask
  task t_slave(input logic pol, pha, lsb, input logic [7:0] tx, snd);
    logic [7:0] got;
    got = 8'h00;
    s_ss = 1'b1;
    s_sck = pol;
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
    {ctrl.cpol, ctrl.cpha, ctrl.lsb_first} = {pol, pha, lsb};
    wr(tx);
    s_ss = 1'b0;
    cyc(4);
    chk({12'h0, pin_oe_n}, 16'h000D);
    for (int i = 0; i < 8; i++) begin
      // phase 0 sets data before the leading edge, phase 1 with it
      if (!pha) s_mosi = snd[lsb ? i : 7 - i];
      cyc(4);
      s_sck = ~pol;
      if (pha) s_mosi = snd[lsb ? i : 7 - i];
      else got = lsb ? {pin_in.miso, got[7:1]} : {got[6:0], pin_in.miso};
      cyc(4);
      s_sck = pol;
      if (pha) got = lsb ? {pin_in.miso, got[7:1]} : {got[6:0], pin_in.miso};
    end
    wait_rx;
    chk(data_rdata, snd);
    chk(got, tx);
    s_ss = 1'b1;
    cyc(3);
    chk({12'h0, pin_oe_n}, 16'h000F);
    rd;
  endtask
  task t_bidir;
    cfg(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 3'h0);
    chk({12'h0, pin_oe_n}, 16'h0003);
    ctrl.bidir_output_enable = 1'b0;
    ctrl.cpol = 1'b1;
    cyc(2);
    chk({12'h0, pin_oe_n}, 16'h0007);
    chk(pin_out.sck, 1'b1);
    cfg(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 3'h0);
    s_ss = 1'b0;
    cyc(3);
    chk({12'h0, pin_oe_n}, 16'h000D);
    s_ss = 1'b1;
    // let the slave drop back to idle before the mode changes
    cyc(1);
  endtask
  task t_ss;
    cfg(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0, 3'h0);
    chk({12'h0, pin_oe_n}, 16'h0002);
    wr(8'h0F);
    cyc(1);
    chk({busy, pin_out.ss}, 16'h0002);
    ctrl.select_output_enable = 1'b0;
    s_ss = 1'b0;
    cyc(3);
    chk({mode_fault_flag, pin_oe_n}, 16'h0013);
    s_ss = 1'b1;
    mode_fault_clr = 1'b1;
    cyc(1);
    mode_fault_clr = 1'b0;
    chk(mode_fault_flag, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////
  // reset held five cycles, then each scenario in turn
  initial begin
    {resetn, clock_gate_wr, data_wr, data_rd, mode_fault_clr} = '0;
    {s_sck, s_mosi, data_wdata, m_tx} = '0;
    ctrl = '0;
    clock_gate_wdata = 1'b1;
    s_ss = 1'b1;
    cyc(5);
    resetn = 1'b1;
    chk({clock_gate_bit, transmit_empty_flag, receive_full_flag, busy,
      pin_oe_n}, 16'h00CF);
    chk({12'h0, pin_out}, 16'h0001);
    t_master(3'h0, 3'h0, 16'd1);
    t_master(3'h2, 3'h1, 16'd6);
    t_master(3'h7, 3'h7, 16'd1024);
    t_off;
    t_gate;
    t_slave(1'b0, 1'b0, 1'b0, 8'hC3, 8'h5A);
    t_slave(1'b1, 1'b1, 1'b1, 8'h1E, 8'h61);
    t_bidir;
    t_ss;
    end_sim;
  end
endmodule

/* tb/spi_core_chk.sv */
`timescale 1ns/1ps
module spi_core_chk (
  input wire logic core_clk, // bus clock
  input wire logic resetn, // reset, low active
  input spi_pkg::ctrl_s ctrl, // control bits
  input wire logic data_wr, // write strobe
  input spi_pkg::pin_set_s pin_in, // pin levels
  input spi_pkg::pin_set_s pin_oe_n, // drive enables
  input wire logic transmit_empty_flag, // buffer free
  input wire logic clock_gate_bit, // gate state
  input wire logic busy // transfer running
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  logic on;
  logic mst;
  // routing only applies while enabled and clocked
  assign on = ctrl.system_enable_bit && clock_gate_bit;
  assign mst = on && ctrl.master_mode;
  //////////////////////////////////////////////////////////////////////
  sequence s_wr;
    data_wr && on;
  endsequence
  // two samples, since select is seen through an edge detector
  sequence s_desel;
    (on && !ctrl.master_mode && pin_in.ss) [*2];
  endsequence
  property p_gate;
    !clock_gate_bit |=> $stable(pin_oe_n) && $stable(busy);
  endproperty
  property p_off;
    clock_gate_bit && !ctrl.system_enable_bit
      |=> &pin_oe_n && !busy && transmit_empty_flag;
  endproperty
  property p_wr;
    s_wr |=> !transmit_empty_flag;
  endproperty
  property p_mst;
    mst && !ctrl.bidir_pin_select |=> pin_oe_n[3:1] == 3'h1;
  endproperty
  property p_slv;
    on && !ctrl.master_mode
      |=> pin_oe_n.sck && pin_oe_n.mosi && pin_oe_n.ss;
  endproperty
  property p_desel;
    s_desel |=> pin_oe_n.miso;
  endproperty
  property p_bidir;
    mst && ctrl.bidir_pin_select |=> pin_oe_n.miso
      && pin_oe_n.mosi != $past(ctrl.bidir_output_enable);
  endproperty
  property p_ssout;
    mst && ctrl.mode_fault_enable && ctrl.select_output_enable
      |=> !pin_oe_n.ss;
  endproperty
  a_gate: assert property (p_gate)
    else $error("state moved while gated");
  a_off: assert property (p_off)
    else $error("disabled module still active");
  a_wr: assert property (p_wr)
    else $error("write not taken");
  a_mst: assert property (p_mst)
    else $error("master pin routing wrong");
  a_slv: assert property (p_slv)
    else $error("slave drives an input pin");
  a_desel: assert property (p_desel)
    else $error("deselected slave drives data");
  a_bidir: assert property (p_bidir)
    else $error("bidir master routing wrong");
  a_ssout: assert property (p_ssout)
    else $error("select output not driven");
endmodule
bind spi_core spi_core_chk u_spi_core_chk (
  .core_clk, .resetn, .ctrl, .data_wr, .pin_in, .pin_oe_n,
  .transmit_empty_flag, .clock_gate_bit, .busy
);

/* tb/spi_slave_model.sv */
`timescale 1ns/1ps
module spi_slave_model (
  input wire logic sck, // clock from master
  input wire logic mosi, // data from master
  input wire logic sel_n, // select, low active
  input wire logic [7:0] tx_byte, // reply byte
  output logic miso, // data to master
  output logic [7:0] rx_byte // bits taken in
);
  logic [7:0] sh = 8'h00;
  // idle-low clock: sample on rise, shift on fall, msb first
  always @(negedge sel_n) sh <= tx_byte;
  always @(posedge sck) if (!sel_n) rx_byte <= {rx_byte[6:0], mosi};
  always @(negedge sck) if (!sel_n) sh <= {sh[6:0], 1'b0};
  // released line shows the inverse so a stale bit never passes
  assign miso = sel_n ? ~sh[7] : sh[7];
endmodule
